// >>> scard_card_model.sv
// Behavioural card on the shared open-drain data line
`timescale 1ns/10ps
module scard_card_model #(
	parameter int ETU = 32  // Cycles per etu
) (
	// Clock and reset
	input  wire logic       ref_clk_in,
	input  wire logic       rst_in,
	// Shared line, resolved level
	input  wire logic       line_in,
	output logic            line_oe_out,
	// Commands from the bench
	input  wire logic       nack_in,
	input  wire logic       send_in,
	input  wire logic [7:0] send_byte_in,
	input  wire logic       send_bad_in,
	// Observations
	output logic [7:0]      got_byte_out,
	output int              n_frames_out,
	output logic            err_seen_out,
	output logic            busy_out
);
	int         cnt;    // Cycles since frame start
	int         n;      // Next count
	logic       rx_on;  // Receiving a frame
	logic       tx_on;  // Sending a frame
	logic       nack_r; // Reject the current frame
	logic [9:0] sh;     // Start, data, parity as sent
	logic [7:0] sr;     // Received data bits
	logic       par;    // Received parity bit
	assign busy_out = rx_on | tx_on;
	// ==========================================================
	// Frame engine, one frame at a time
	always @(posedge ref_clk_in) begin
		n = cnt + 1;
		if (rst_in) begin
			{rx_on, tx_on, line_oe_out, err_seen_out} <= 4'h0;
			cnt <= 0;
			n_frames_out <= 0;
			got_byte_out <= 8'h00;
		end else if (tx_on) begin
			cnt <= n;
			// bits in order, line freed after parity
			line_oe_out <= (n < 10 * ETU) ? !sh[n / ETU] : 1'b0;
			// sample the returned error signal mid-way
			if (n == 11 * ETU) err_seen_out <= !line_in;
			if (n == 12 * ETU) tx_on <= 1'b0;
		end else if (rx_on) begin
			cnt <= n;
			if (n % ETU == ETU / 2 && n / ETU >= 1 && n / ETU <= 8) sr[n / ETU - 1] <= line_in;
			if (n == 9 * ETU + ETU / 2) begin
				par <= line_in;
				n_frames_out <= n_frames_out + 1;
			end
			// low error signal for one etu from 10.5 etu
			if (n == 10 * ETU + ETU / 2) line_oe_out <= nack_r | (^sr ^ par);
			if (n == 11 * ETU + ETU / 2) begin
				line_oe_out <= 1'b0;
				got_byte_out <= sr;
			end
			if (n == 12 * ETU) rx_on <= 1'b0;
		end else if (send_in) begin
			// start low, data lsb first, even parity
			sh <= {^send_byte_in ^ send_bad_in, send_byte_in, 1'b0};
			tx_on <= 1'b1;
			line_oe_out <= 1'b1;
			err_seen_out <= 1'b0;
			cnt <= 0;
		end else if (line_in == 1'b0) begin
			rx_on <= 1'b1;
			nack_r <= nack_in;
			cnt <= 0;
		end
	end
endmodule

// >>> scard_defs.svh
// Register offsets, field positions, reset values and timing counts of the card serial block
`ifndef SCARD_DEFS_SVH
`define SCARD_DEFS_SVH

// ==========================================================
// Register offsets (byte index on the 3-bit register port)
`define OFS_MODE      3'h0
`define OFS_RATE      3'h1
`define OFS_CTRL      3'h2
`define OFS_TXHOLD    3'h3
`define OFS_STATUS    3'h4
`define OFS_RXHOLD    3'h5
`define OFS_CARDMODE  3'h6

// ==========================================================
// Field positions
`define MODE_GSM      7
`define MODE_ODD      4
`define CTRL_TE       5
`define CTRL_RE       4
`define CTRL_CKHI     1
`define CTRL_CKLO     0
`define ST_TX_BUFFER_EMPTY_FLAG       7
`define ST_RDRF       6
`define ST_ORER       5
`define ST_ERS        4
`define ST_PER        3
`define ST_TRANSMIT_END_FLAG       2
`define CM_DIR        3
`define CM_INV        2
`define CM_EN         0

// ==========================================================
// Reset values
`define RATE_RST      8'hFF
`define TXHOLD_RST    8'hFF

// ==========================================================
// Timing: H_RELEASE to H_RX_ERR_OFF in half-etu steps from the start bit edge; PRE_FILL and SCK_HALF in reference clock cycles
`define PRE_FILL      4'hF
`define H_RELEASE     5'h14
`define H_ERR_SAMPLE  5'h16
`define H_GUARD_END   5'h18
`define H_TRANSMIT_END_FLAG_NORM   5'h19
`define H_RETRY       5'h1A
`define H_RX_CHECK    5'h14
`define H_RX_ERR_ON   5'h15
`define H_RX_ERR_OFF  5'h17
`define SCK_HALF      8'h03

`endif

// >>> scard_pkg.sv
// Types shared by the card serial block
package scard_pkg;

	// ==========================================================
	// Sequencer states
	typedef enum logic {TX_IDLE, TX_FRAME} tx_state_t;
	typedef enum logic {RX_IDLE, RX_FRAME} rx_state_t;

	// ==========================================================
	// Register port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// ==========================================================
	// Whole block state
	typedef struct packed {
		logic [7:0]  mode;
		logic [7:0]  rate;
		logic [7:0]  ctrl;
		logic [7:0]  tx_holding_register;
		logic [7:0]  rx_holding_register;
		logic [7:0]  cmode;
		logic        tx_buffer_empty_flag;
		logic        rdrf;
		logic        orer;
		logic        error_signal_status;
		logic        per;
		logic        transmit_end_flag;
		logic [7:0]  seen;
		logic [7:0]  rd_data;
		tx_state_t   tx_st;
		logic [11:0] tx_pre;
		logic [4:0]  tx_h;
		logic [9:0]  tx_fr;
		logic        retx;
		rx_state_t   rx_st;
		logic [11:0] rx_pre;
		logic [4:0]  rx_h;
		logic [9:0]  rx_fr;
		logic        rx_bad;
		logic        line_oe;
		logic        line_sy1;
		logic        line_sy2;
		logic        line_prev;
		logic [7:0]  sck_cnt;
		logic        sck_lvl;
		logic        sck_pin;
		logic        sck_oe;
	} state_t;

endpackage

// >>> scard_serial.sv
// Card serial extension: half-duplex character link with error signalling and retry
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "scard_defs.svh"
module scard_serial (
	// Clock and reset
	input  wire logic              ref_clk_in,
	input  wire logic              rst_in,
	input  wire logic              standby_in,
	// Register port
	input  wire scard_pkg::reg_req_t reg_req_in,
	output logic [7:0]             rd_data_out,
	// Shared open-drain data line
	input  wire logic              line_in,
	output logic                   line_out,
	output logic                   line_oe_out,
	// Card clock pin
	output logic                   sck_out,
	output logic                   sck_oe_out
);

	// ==========================================================
	// State registers
	scard_pkg::state_t s_r;     // Registered state
	scard_pkg::state_t s_nxt;   // Next state
	scard_pkg::state_t rst_v;   // Reset and standby image
	logic [7:0]  status_v;      // Status as seen by software
	logic [7:0]  tx_eff;        // Data after inversion
	logic [7:0]  tx_rev;        // Reversed data
	logic [7:0]  rx_rev;        // Reversed received bits
	logic [7:0]  rx_data;       // Received character
	logic        tx_tick;       // Transmit half-etu step
	logic        rx_tick;       // Receive half-etu step
	logic        rx_line;       // Receiver's view of the line
	logic        en;            // Card mode active
	logic        gm;            // GSM timing mode
	logic [4:0]  tx_hn;         // Transmit step after increment
	logic [4:0]  rx_hn;         // Receive step after increment

	// Outputs straight from state flops, except line_out which is tied low
	assign rd_data_out = s_r.rd_data;
	assign line_out    = 1'b0;
	assign line_oe_out = s_r.line_oe;
	assign sck_out     = s_r.sck_pin;
	assign sck_oe_out  = s_r.sck_oe;

	// ==========================================================
	// Bit order helpers
	// order reversal
	genvar j;
	generate
		for (j = 0; j < 8; j = j + 1) begin : g_rev
			assign tx_rev[j] = tx_eff[7-j];
			assign rx_rev[j] = s_r.rx_fr[8-j];
		end
	endgenerate

	// ==========================================================
	// Next-state logic
	always_comb begin
		s_nxt = s_r;
		// Reset image, also used on standby entry
		rst_v = '0;
		rst_v.rate = `RATE_RST;
		rst_v.tx_holding_register  = `TXHOLD_RST;
		rst_v.tx_buffer_empty_flag = 1'b1;
		rst_v.transmit_end_flag = 1'b1;
		rst_v.line_sy1 = 1'b1;
		rst_v.line_sy2 = 1'b1;
		rst_v.line_prev = 1'b1;
		en = s_r.cmode[`CM_EN];
		gm = s_r.mode[`MODE_GSM];
		// bit four shows only error status
		status_v = {s_r.tx_buffer_empty_flag, s_r.rdrf, s_r.orer, s_r.error_signal_status, s_r.per, s_r.transmit_end_flag, 2'b00};
		tx_eff  = s_r.tx_holding_register ^ {8{s_r.cmode[`CM_INV]}};
		rx_data = (s_r.cmode[`CM_DIR] ? rx_rev : s_r.rx_fr[8:1]) ^ {8{s_r.cmode[`CM_INV]}};
		tx_tick = (s_r.tx_pre == {s_r.rate, `PRE_FILL});
		rx_tick = (s_r.rx_pre == {s_r.rate, `PRE_FILL});
		tx_hn = s_r.tx_h + 5'h01;
		rx_hn = s_r.rx_h + 5'h01;
		// Two-flop line synchroniser
		s_nxt.line_sy1 = line_in;
		s_nxt.line_sy2 = s_r.line_sy1;
		rx_line = s_r.line_sy2 & ~(s_r.ctrl[`CTRL_TE] & s_r.ctrl[`CTRL_RE] & s_r.line_oe);
		s_nxt.line_prev = rx_line;
		s_nxt.rd_data = 8'h00;

		// Register reads; unmapped reads return zero
		if (reg_req_in.rd) begin
			case (reg_req_in.addr)
				`OFS_MODE:     s_nxt.rd_data = s_r.mode;
				`OFS_RATE:     s_nxt.rd_data = s_r.rate;
				`OFS_CTRL:     s_nxt.rd_data = s_r.ctrl;
				`OFS_TXHOLD:   s_nxt.rd_data = s_r.tx_holding_register;
				`OFS_RXHOLD:   s_nxt.rd_data = s_r.rx_holding_register;
				`OFS_CARDMODE: s_nxt.rd_data = s_r.cmode & 8'h0D;
				`OFS_STATUS: begin
					s_nxt.rd_data = status_v;
					// Remember which flags were seen as one
					s_nxt.seen = status_v;
				end
				default:       s_nxt.rd_data = 8'h00;
			endcase
		end

		// Register writes; status flags only clear after a read of one
		if (reg_req_in.wr) begin
			case (reg_req_in.addr)
				`OFS_MODE:     s_nxt.mode = reg_req_in.wdata;
				`OFS_RATE:     s_nxt.rate = reg_req_in.wdata;
				`OFS_CTRL:     s_nxt.ctrl = reg_req_in.wdata;
				`OFS_TXHOLD:   s_nxt.tx_holding_register = reg_req_in.wdata;
				`OFS_CARDMODE: s_nxt.cmode = reg_req_in.wdata & 8'h0D;
				`OFS_STATUS: begin
					if (!reg_req_in.wdata[`ST_TX_BUFFER_EMPTY_FLAG] && s_r.seen[`ST_TX_BUFFER_EMPTY_FLAG]) begin
						s_nxt.tx_buffer_empty_flag = 1'b0;
						s_nxt.transmit_end_flag = 1'b0;
					end
					if (!reg_req_in.wdata[`ST_RDRF] && s_r.seen[`ST_RDRF])
						s_nxt.rdrf = 1'b0;
					if (!reg_req_in.wdata[`ST_ORER] && s_r.seen[`ST_ORER])
						s_nxt.orer = 1'b0;
					if (!reg_req_in.wdata[`ST_ERS] && s_r.seen[`ST_ERS])
						s_nxt.error_signal_status = 1'b0;
					if (!reg_req_in.wdata[`ST_PER] && s_r.seen[`ST_PER])
						s_nxt.per = 1'b0;
					s_nxt.seen = 8'h00;
				end
				default: ;
			endcase
		end

		// Transmit sequencer; flag sets come after clears so a set wins
		// only start-stop framing exists
		case (s_r.tx_st)
			scard_pkg::TX_IDLE: begin
				if (en && s_r.ctrl[`CTRL_TE] && !s_nxt.tx_buffer_empty_flag) begin
					s_nxt.tx_fr = {(^s_r.tx_holding_register) ^ s_r.mode[`MODE_ODD],
						(s_r.cmode[`CM_DIR] ? tx_rev : tx_eff), 1'b0};
					s_nxt.tx_buffer_empty_flag = 1'b1;
					s_nxt.tx_st = scard_pkg::TX_FRAME;
					s_nxt.tx_pre = 12'h000;
					s_nxt.tx_h = 5'h00;
					s_nxt.retx = 1'b0;
				end
			end
			scard_pkg::TX_FRAME: begin
				s_nxt.tx_pre = tx_tick ? 12'h000 : s_r.tx_pre + 12'h001;
				if (tx_tick) begin
					s_nxt.tx_h = tx_hn;
					if (tx_hn == `H_ERR_SAMPLE && !s_r.line_sy2) begin
						s_nxt.error_signal_status = 1'b1;
						s_nxt.retx = 1'b1;
					end
					if (tx_hn == `H_ERR_SAMPLE && s_r.line_sy2 && gm && s_r.tx_buffer_empty_flag && !s_r.error_signal_status)
						s_nxt.transmit_end_flag = 1'b1;
					if (tx_hn == `H_TRANSMIT_END_FLAG_NORM && !s_r.retx && !gm && s_r.tx_buffer_empty_flag && !s_r.error_signal_status)
						s_nxt.transmit_end_flag = 1'b1;
					if (tx_hn == `H_RETRY && s_r.retx) begin
						s_nxt.tx_h = 5'h00;
						s_nxt.retx = 1'b0;
					end
					if (!s_r.retx && tx_hn == (gm ? `H_GUARD_END : `H_TRANSMIT_END_FLAG_NORM))
						s_nxt.tx_st = scard_pkg::TX_IDLE;
				end
				// Dropping enable abandons the frame; no flag is cleared
				if (!en || !s_r.ctrl[`CTRL_TE])
					s_nxt.tx_st = scard_pkg::TX_IDLE;
			end
			default: s_nxt.tx_st = scard_pkg::TX_IDLE;
		endcase

		// Receive sequencer
		case (s_r.rx_st)
			scard_pkg::RX_IDLE: begin
				if (en && s_r.ctrl[`CTRL_RE] && s_r.line_prev && !rx_line) begin
					s_nxt.rx_st = scard_pkg::RX_FRAME;
					s_nxt.rx_pre = 12'h000;
					s_nxt.rx_h = 5'h00;
					s_nxt.rx_bad = 1'b0;
				end
			end
			scard_pkg::RX_FRAME: begin
				s_nxt.rx_pre = rx_tick ? 12'h000 : s_r.rx_pre + 12'h001;
				if (rx_tick) begin
					s_nxt.rx_h = rx_hn;
					// Sample each bit at its middle
					if (rx_hn[0] && rx_hn < `H_RX_CHECK)
						s_nxt.rx_fr[rx_hn[4:1]] = rx_line;
					if (rx_hn == `H_RX_CHECK) begin
						if ((^rx_data) ^ s_r.rx_fr[9] ^ s_r.mode[`MODE_ODD]) begin
							s_nxt.rx_bad = 1'b1;
							s_nxt.per = 1'b1;
						end else if (s_r.rdrf) begin
							s_nxt.orer = 1'b1;
						end else begin
							s_nxt.rx_holding_register = rx_data;
							s_nxt.rdrf = 1'b1;
						end
					end
					if (rx_hn == `H_RX_ERR_OFF)
						s_nxt.rx_st = scard_pkg::RX_IDLE;
				end
				if (!en || !s_r.ctrl[`CTRL_RE])
					s_nxt.rx_st = scard_pkg::RX_IDLE;
			end
			default: s_nxt.rx_st = scard_pkg::RX_IDLE;
		endcase

		// drive only while a low bit is due
		// error signal from 10.5 to 11.5 etu
		s_nxt.line_oe =
			((s_nxt.tx_st == scard_pkg::TX_FRAME) && (s_nxt.tx_h < `H_RELEASE) &&
			!s_nxt.tx_fr[s_nxt.tx_h[4:1]]) ||
			((s_nxt.rx_st == scard_pkg::RX_FRAME) && s_nxt.rx_bad &&
			(s_nxt.rx_h >= `H_RX_ERR_ON) && (s_nxt.rx_h < `H_RX_ERR_OFF));

		s_nxt.sck_cnt = (s_r.sck_cnt == `SCK_HALF) ? 8'h00 : s_r.sck_cnt + 8'h01;
		if (s_r.sck_cnt == `SCK_HALF)
			s_nxt.sck_lvl = ~s_r.sck_lvl;
		if (!en) begin
			s_nxt.sck_oe = 1'b0;
			s_nxt.sck_pin = 1'b0;
		end else if (gm) begin
			s_nxt.sck_oe = 1'b1;
			s_nxt.sck_pin = s_r.ctrl[`CTRL_CKLO] ? s_r.sck_lvl : s_r.ctrl[`CTRL_CKHI];
		end else begin
			s_nxt.sck_oe = (s_r.ctrl[`CTRL_CKHI:`CTRL_CKLO] == 2'b01);
			s_nxt.sck_pin = s_r.sck_lvl;
		end

		if (!s_r.ctrl[`CTRL_TE] && !s_r.error_signal_status)
			s_nxt.transmit_end_flag = 1'b1;
		if (standby_in)
			s_nxt = rst_v;
	end

	// ==========================================================
	// State register, synchronous reset
	always_ff @(posedge ref_clk_in) begin
		if (rst_in)
			s_r <= rst_v;
		else
			s_r <= s_nxt;
	end

	// ==========================================================
	// Checks
	transmit_end_flag_reset_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$fell(rst_in) |-> s_r.transmit_end_flag && s_r.tx_buffer_empty_flag && !s_r.error_signal_status)
		else $error("transmit end not set after reset");
	ers_keep_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(reg_req_in.wr && reg_req_in.addr == `OFS_STATUS && reg_req_in.wdata[`ST_ERS]
		&& s_r.error_signal_status && !standby_in) |=> s_r.error_signal_status)
		else $error("writing one cleared error status");
	ers_te_off_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(reg_req_in.wr && reg_req_in.addr == `OFS_CTRL && !reg_req_in.wdata[`CTRL_TE]
		&& s_r.error_signal_status && !standby_in) |=> s_r.error_signal_status ##1 s_r.error_signal_status)
		else $error("disabling transmitter lost error status");
	tx_start_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(s_r.tx_st == scard_pkg::TX_FRAME && s_r.tx_h == 5'h00) |-> s_r.line_oe)
		else $error("start bit not driven low");
	tx_release_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(s_r.tx_st == scard_pkg::TX_FRAME && s_r.tx_h >= `H_RELEASE
		&& s_r.rx_st == scard_pkg::RX_IDLE) |-> !s_r.line_oe)
		else $error("line held after parity bit");
	transmit_end_flag_gsm_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(s_r.tx_st == scard_pkg::TX_FRAME && tx_tick && tx_hn == `H_ERR_SAMPLE && gm
		&& s_r.line_sy2 && s_r.tx_buffer_empty_flag && !s_r.error_signal_status && !standby_in) |=> s_r.transmit_end_flag)
		else $error("GSM transmit end missed");
	transmit_end_flag_norm_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(s_r.tx_st == scard_pkg::TX_FRAME && tx_tick && tx_hn == `H_TRANSMIT_END_FLAG_NORM && !gm
		&& !s_r.retx && s_r.tx_buffer_empty_flag && !s_r.error_signal_status && !standby_in) |=> s_r.transmit_end_flag)
		else $error("normal transmit end missed");
	ers_set_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(s_r.tx_st == scard_pkg::TX_FRAME && tx_tick && tx_hn == `H_ERR_SAMPLE
		&& !s_r.line_sy2 && !standby_in) |=> s_r.error_signal_status && s_r.retx)
		else $error("sampled error signal not flagged");
	err_pulse_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(s_r.rx_st == scard_pkg::RX_FRAME && s_r.rx_bad && s_r.rx_h == `H_RX_ERR_ON)
		|-> s_r.line_oe)
		else $error("error signal not driven");
	sck_low_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(en && gm && s_r.ctrl[`CTRL_CKHI:`CTRL_CKLO] == 2'b00)[*2] |-> s_r.sck_oe && !s_r.sck_pin)
		else $error("card clock not held low");
	transmit_end_flag_idle_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(!s_r.ctrl[`CTRL_TE] && !s_r.error_signal_status) |=> s_r.transmit_end_flag)
		else $error("transmit end not set while transmitter idle");
	card_off_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		!en |=> !s_r.sck_oe && !s_r.line_oe)
		else $error("pins driven outside card mode");
	sck_input_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(en && !gm && !s_r.ctrl[`CTRL_CKLO]) |=> !s_r.sck_oe)
		else $error("card clock pin driven without clock select");
	rx_quiet_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(s_r.tx_st == scard_pkg::TX_IDLE && !s_r.rx_bad) |-> !s_r.line_oe)
		else $error("line pulled with nothing to send");
	resend_start_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(s_r.tx_st == scard_pkg::TX_FRAME && tx_tick && tx_hn == `H_RETRY && s_r.retx
		&& en && s_r.ctrl[`CTRL_TE] && !standby_in) |=> s_r.tx_st == scard_pkg::TX_FRAME
		&& s_r.line_oe)
		else $error("resend did not start");

endmodule

// >>> scard_serial_tb.sv
// Self-checking bench of the card serial block
`timescale 1ns/10ps
`include "scard_defs.svh"
module scard_serial_tb;
	localparam int H = 16;                     // Half etu at rate 0
	logic                ref_clk_in = 1'b0;
	logic                rst_in     = 1'b1;
	logic                standby_in = 1'b0;
	scard_pkg::reg_req_t req        = '0;      // Register port request
	logic [7:0]          rd_data_out, st, v, d, got_byte;
	logic                line_oe_out, line_out, sck_out, sck_oe_out, card_oe, err_seen, busy;
	logic                nack = 1'b0, send = 1'b0, bad = 1'b0;
	logic [7:0]          sbyte = 8'h00;
	wire                 line = ~(line_oe_out | card_oe);  // Pull-up wins when nobody pulls
	int                  n_errors = 0, checks = 0, nfr, t, n_frames;
	logic [31:0]         seed = 32'h00016F1F;  // Fixed seed
	logic [7:0]          rst_val [7] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'h84, 8'h00, 8'h00};
	always #5 ref_clk_in = ~ref_clk_in;
	scard_serial scard_serial_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.standby_in(standby_in), .reg_req_in(req), .rd_data_out(rd_data_out),
		.line_in(line), .line_out(line_out), .line_oe_out(line_oe_out),
		.sck_out(sck_out), .sck_oe_out(sck_oe_out));
	scard_card_model #(.ETU(2 * H)) scard_card_model_i (.ref_clk_in(ref_clk_in),
		.rst_in(rst_in), .line_in(line), .line_oe_out(card_oe), .nack_in(nack),
		.send_in(send), .send_byte_in(sbyte), .send_bad_in(bad), .got_byte_out(got_byte),
		.n_frames_out(n_frames), .err_seen_out(err_seen), .busy_out(busy));
	// ==========================================================
	// Helpers
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge ref_clk_in);
	endtask
	// One write cycle, then a quiet cycle so strobes never collide
	task automatic wr(input logic [2:0] a, input logic [7:0] w);
		req.wr <= 1'b1;
		req.addr <= a;
		req.wdata <= w;
		cyc(1);
		req.wr <= 1'b0;
		cyc(1);
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] r);
		req.rd <= 1'b1;
		req.addr <= a;
		cyc(1);
		req.rd <= 1'b0;
		@(negedge ref_clk_in);
		r = rd_data_out;
		cyc(1);
	endtask
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	// Wire image of a byte: inversion, then order
	function automatic logic [7:0] wire_of(input logic [7:0] b, input logic dir, input logic inv);
		logic [7:0] x, y;
		x = inv ? ~b : b;
		y = {<<{x}};
		return dir ? y : x;
	endfunction
	// Load, clear the empty flag, wait for the start bit
	task automatic start_tx(input logic [7:0] b);
		wr(`OFS_TXHOLD, b);
		rd(`OFS_STATUS, st);
		wr(`OFS_STATUS, 8'h7F);
		t = 0;
		while (line === 1'b1 && t < 3000) begin
			@(negedge ref_clk_in);
			t++;
		end
		if (t >= 3000) n_errors++;
		cyc(1);
		rd(`OFS_STATUS, st);
		chk(st & 8'h04, 8'h00);
	endtask
	task automatic give_verdict();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// ==========================================================
	// Watchdog, well beyond the whole sequence
	initial begin
		cyc(40000);
		n_errors++;
		give_verdict();
	end
	// ==========================================================
	// Main sequence
	initial begin
		cyc(4);
		rst_in <= 1'b0;
		cyc(1);
		// Reset values and one unmapped index
		for (int a = 0; a < 8; a++) begin
			rd(a[2:0], v);
			chk(v, (a < 7) ? rst_val[a] : 8'h00);
		end
		wr(`OFS_RATE, 8'h00);
		wr(`OFS_CARDMODE, 8'h01);
		wr(`OFS_CTRL, 8'h20);
		// End flag timing in both modes
		for (int g = 0; g < 2; g++) begin
			wr(`OFS_MODE, {g[0], 7'h00});
			d = rnd();
			start_tx(d);
			cyc(22 * H + 4);
			rd(`OFS_STATUS, st);
			chk(st & 8'h94, g ? 8'h84 : 8'h80);
			cyc(3 * H);
			rd(`OFS_STATUS, st);
			chk(st & 8'h94, 8'h84);
			chk(got_byte, d);
		end
		// Inverse convention: msb first, inverted data
		wr(`OFS_MODE, 8'h00);
		wr(`OFS_CARDMODE, 8'h0D);
		d = rnd();
		start_tx(d);
		cyc(26 * H);
		chk(got_byte, wire_of(d, 1'b1, 1'b1));
		wr(`OFS_CARDMODE, 8'h01);
		// Card rejects the first frame, accepts the resend
		nack <= 1'b1;
		nfr = n_frames;
		d = rnd();
		start_tx(d);
		t = 0;
		while (n_frames == nfr && t < 1000) begin
			cyc(1);
			t++;
		end
		nack <= 1'b0;
		cyc(36 * H);
		rd(`OFS_STATUS, st);
		chk(st & 8'h14, 8'h10);
		chk(8'(n_frames - nfr), 8'h02);
		chk(got_byte, d);
		wr(`OFS_CTRL, 8'h00);
		rd(`OFS_STATUS, st);
		chk(st & 8'h14, 8'h10);
		wr(`OFS_STATUS, 8'hFF);
		rd(`OFS_STATUS, st);
		chk(st & 8'h14, 8'h10);
		wr(`OFS_STATUS, 8'hEF);
		rd(`OFS_STATUS, st);
		chk(st & 8'h14, 8'h04);
		// Both enables: own frame comes back into the receiver
		wr(`OFS_CTRL, 8'h30);
		d = rnd();
		start_tx(d);
		cyc(26 * H);
		rd(`OFS_STATUS, st);
		chk(st & 8'h48, 8'h40);
		rd(`OFS_RXHOLD, v);
		chk(v, d);
		wr(`OFS_STATUS, 8'hBF);
		// Reception: three good frames, a bad parity, then odd parity
		wr(`OFS_CTRL, 8'h10);
		for (int k = 0; k < 5; k++) begin
			d = rnd();
			if (k == 4) wr(`OFS_MODE, 8'h10);
			bad <= (k >= 3);
			sbyte <= d;
			send <= 1'b1;
			cyc(1);
			send <= 1'b0;
			cyc(26 * H);
			chk({7'h00, err_seen}, {7'h00, k == 3});
			chk({7'h00, line_out}, 8'h00);
			rd(`OFS_STATUS, st);
			chk(st & 8'h48, (k == 3) ? 8'h08 : 8'h40);
			if (k != 3) begin
				rd(`OFS_RXHOLD, v);
				chk(v, d);
			end
			wr(`OFS_STATUS, (k == 3) ? 8'hF7 : 8'hBF);
		end
		// Clock pin in every legal select code
		wr(`OFS_CTRL, 8'h00);
		for (int m = 0; m < 8; m++) begin
			logic g, tog, lvl, oe;
			g = m[2];
			if (!g && m[1]) continue;
			wr(`OFS_MODE, {g, 7'h00});
			wr(`OFS_CTRL, {6'h00, m[1:0]});
			cyc(4);
			oe = 1'b1;
			tog = 1'b0;
			lvl = sck_out;
			repeat (9) begin
				@(negedge ref_clk_in);
				oe = oe & sck_oe_out;
				tog = tog | (sck_out !== lvl);
			end
			cyc(1);
			chk({6'h00, oe, tog & oe}, {6'h00, g | m[0], m[0]});
			if (g && !m[0]) chk({7'h00, lvl}, {7'h00, m[1]});
		end
		// Standby brings back the reset image
		standby_in <= 1'b1;
		cyc(2);
		standby_in <= 1'b0;
		cyc(1);
		rd(`OFS_STATUS, st);
		chk(st, 8'h84);
		give_verdict();
	end
endmodule
